// [xlate_miss_pkg.sv]
// package for the translation miss sequencer and privileged register port
// assumes one core clock; privileged register accesses arrive as strobes
package xlate_miss_pkg;
   // ==========================================================
   // privileged register selectors (index space of the core)
   localparam logic [3:0] SEL_TAG_STAGING   = 4'h0;
   localparam logic [3:0] SEL_IXLATE_ENTRY  = 4'h1;
   localparam logic [3:0] SEL_IXLATE_HOLD   = 4'h2;
   localparam logic [3:0] SEL_DXLATE_ENTRY  = 4'h3;
   localparam logic [3:0] SEL_DXLATE_HOLD   = 4'h4;
   localparam logic [3:0] SEL_PAGE_SIZE     = 4'h5;
   localparam logic [3:0] SEL_EXC_RET_ADDR  = 4'h6;
   localparam logic [3:0] SEL_FAULT_VA      = 4'h7;
   localparam logic [3:0] SEL_FAULT_STATUS  = 4'h8;
   localparam logic [3:0] SEL_EXC_SUMMARY   = 4'h9;
   // ==========================================================
   // buffer geometry
   localparam int SMALL_ENTRIES = 8;
   localparam int LARGE_ENTRIES = 4;
   // ==========================================================
   // trap shadow lengths in cycles
   localparam logic [5:0] SHADOW_INT    = 6'h03;
   localparam logic [5:0] SHADOW_MULL   = 6'h16;
   localparam logic [5:0] SHADOW_MULQ   = 6'h18;
   localparam logic [5:0] SHADOW_FLT    = 6'h06;
   localparam logic [5:0] SHADOW_DIVS   = 6'h22;
   localparam logic [5:0] SHADOW_DIVT   = 6'h3F;
   // trap class codes
   typedef enum logic [2:0] {
      TRAP_NONE = 3'h0, TRAP_INT = 3'h1, TRAP_MULL = 3'h2,
      TRAP_MULQ = 3'h3, TRAP_FLT = 3'h4, TRAP_DIVS = 3'h5,
      TRAP_DIVT = 3'h6
   } trap_class_t;
   // drain of in-flight work before entry, in cycles
   localparam logic [3:0] DRAIN_CYCLES = 4'h4;
   // entry vectors
   localparam logic [63:0] VEC_IMISS = 64'h0000_0000_0000_03E0;
   localparam logic [63:0] VEC_DMISS = 64'h0000_0000_0000_08E0;
   localparam logic [63:0] VEC_DMISS_PRIV = 64'h0000_0000_0000_09E0;
   // ==========================================================
   // privileged register access bundle
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  sel;
      logic [63:0] wdata;
   } priv_acc_t;
   // one translation entry
   typedef struct packed {
      logic        valid;
      logic [29:0] tag;
      logic [63:0] entry;
   } xent_t;
endpackage : xlate_miss_pkg

// [xlate_miss_priv_timing.sv]
// translation miss sequencing and privileged register access timing
// assumes firmware keeps its own spacing rules; inputs are core-clocked
// Rules from the document, for the block and for firmware
// (RL1) override outside privileged mode ignores instruction buffer regs
// (RL2) firmware avoids exceptions while writing privileged code base
// (RL3) trap shadow held 3/22/24/6/34/63 cycles per op class
// (RL4) firmware leaves two idle cycles between entry write and tag write
// (RL5) traps coinciding with a machine check are not re-raised
// (RL6) firmware waits three cycles before reading the entry hold
// (RL7) entry read copies into hold register; destination value undefined
// (RL8) firmware never reads one entry register in consecutive cycles
// (RL9) memory error one cycle earlier aborts access, pointer still moves
// (RL10) firmware writes entry mapping return address last
// (RL11) no cache-missing load within two cycles after physical store
// (RL12) firmware waits ten cycles after address space number update
// (RL13) firmware waits nine cycles after cache flush writes
// (RL14) firmware never writes size select right after entry write
// (RL15) machine check in privileged mode may record early restart address
// (RL16) instruction miss latches pc, flushes, drains, enters privileged
// (RL17) firmware writes tag, size select, waits, then entry
// (RL18) tag goes to staging; entry write loads tag and entry together
// (RL19) data miss latches address and status, locks, drains, vectors
// (RL20) data misses are taken in privileged mode too
// (RL21) reading fault address unlocks it and fault status
// (RL22) firmware skips prefetch-hint faults by bumping return address
// (RL23) twelve entries: eight small, four large, each its own pointer
// (RL24) miss registers hold until firmware reads or rewrites them
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ns
module xlate_miss_priv_timing
   import xlate_miss_pkg::*;
#(
   parameter int DATA_ENTRIES = 8
) (
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_SYS_RST,
   input  wire priv_acc_t   I_PRIV_ACC,
   input  wire logic        I_PRIV_MODE_OVERRIDE,
   input  wire logic        I_IMISS,
   input  wire logic [63:0] I_IMISS_VPC,
   input  wire logic        I_DMISS,
   input  wire logic [63:0] I_DMISS_VA,
   input  wire logic [63:0] I_DMISS_PC,
   input  wire logic [15:0] I_DMISS_STATUS,
   input  wire logic        I_DMM_ERROR,
   input  wire logic        I_MACHINE_CHECK,
   input  wire logic [63:0] I_MACHINE_CHECK_PC,
   input  wire logic        I_RETURN,
   input  wire trap_class_t I_TRAP_OP,
   input  wire logic        I_TRAP_ERR,
   output logic [63:0] O_RD_DATA,
   output logic        O_RD_VALID,
   output logic        O_PRIV_MODE,
   output logic        O_FLUSH,
   output logic        O_VECTOR_VALID,
   output logic [63:0] O_VECTOR,
   output logic        O_TRAP_PENDING,
   output logic        O_TRAP_RAISE
);
   // ==========================================================
   // state
   typedef enum logic [3:0] {
      ST_RUN    = 4'b0001,
      ST_DRAIN  = 4'b0010,
      ST_VECTOR = 4'b0100,
      ST_PRIV   = 4'b1000
   } seq_t;

   typedef struct packed {
      seq_t        seq;
      logic        priv;
      logic        dmiss_kind;
      logic        from_priv;
      logic [3:0]  drain;
      logic [63:0] exception_return_address;
      logic [63:0] fault_va;
      logic [15:0] fault_stat;
      logic        locked;
      logic [29:0] tag_stage;
      logic [63:0] size_sel;
      logic [63:0] ihold;
      logic [63:0] dhold;
      logic [2:0]  small_ptr;
      logic [1:0]  large_ptr;
      logic [2:0]  dptr;
      logic        dmm_prev;
      logic [5:0]  shadow;
      logic        trap_err;
      logic [7:0]  exception_summary;
      logic [63:0] rd_data;
      logic        rd_valid;
      logic        flush;
      logic        vec_valid;
      logic [63:0] vec;
      logic        raise;
   } state_t;

   state_t s_q;
   state_t s_d;

   // entry arrays sit outside the struct; they are wide memories
   xent_t small_q [SMALL_ENTRIES];
   xent_t large_q [LARGE_ENTRIES];
   xent_t data_q  [DATA_ENTRIES];

   // shadow length for an op class
   function automatic logic [5:0] shadow_len(input trap_class_t c);
      unique case (c)
         TRAP_INT:  shadow_len = SHADOW_INT;
         TRAP_MULL: shadow_len = SHADOW_MULL;
         TRAP_MULQ: shadow_len = SHADOW_MULQ;
         TRAP_FLT:  shadow_len = SHADOW_FLT;
         TRAP_DIVS: shadow_len = SHADOW_DIVS;
         TRAP_DIVT: shadow_len = SHADOW_DIVT;
         default:   shadow_len = 6'h00;
      endcase
   endfunction : shadow_len

   // large page chosen by bit 0 of the latched size select
   logic large_pg;
   logic ibuf_sel;
   logic acc_ok;
   logic dmm_abort;
   assign large_pg  = s_q.size_sel[0];
   assign ibuf_sel  = (I_PRIV_ACC.sel == SEL_TAG_STAGING) ||
                      (I_PRIV_ACC.sel == SEL_IXLATE_ENTRY) ||
                      (I_PRIV_ACC.sel == SEL_IXLATE_HOLD);
   // outside privileged mode only the override lets an access through,
   // and never one to the instruction buffer registers
   assign acc_ok    = s_q.priv || (I_PRIV_MODE_OVERRIDE && !ibuf_sel); // RL1
   assign dmm_abort = s_q.dmm_prev &&
                      (I_PRIV_ACC.sel == SEL_IXLATE_ENTRY); // RL9

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.rd_valid  = 1'b0;
      s_d.flush     = 1'b0;
      s_d.vec_valid = 1'b0;
      s_d.raise     = 1'b0;
      s_d.dmm_prev  = I_DMM_ERROR;

      // trap shadow counter; a new op restarts it
      if (I_TRAP_OP != TRAP_NONE) begin
         s_d.shadow = shadow_len(I_TRAP_OP); // RL3
      end else if (s_q.shadow != 6'h00) begin
         s_d.shadow = s_q.shadow - 6'h01; // RL3
      end
      // raise first so a fresh error in the same cycle is not lost
      if (s_q.trap_err && !I_MACHINE_CHECK) begin
         s_d.raise    = 1'b1;
         s_d.trap_err = 1'b0;
      end
      if (I_TRAP_ERR && s_q.shadow != 6'h00) begin
         s_d.trap_err = 1'b1;
      end

      // machine check swallows a coinciding trap, records it in summary
      if (I_MACHINE_CHECK) begin
         s_d.exception_summary[0] = s_q.trap_err || I_TRAP_ERR; // RL5
         s_d.trap_err   = 1'b0; // RL5
         s_d.raise      = 1'b0;
         // restart pc taken as given; may sit one instruction early
         s_d.exception_return_address   = I_MACHINE_CHECK_PC; // RL15
         s_d.priv       = 1'b1;
      end

      // privileged register writes
      if (I_PRIV_ACC.wr && acc_ok && !dmm_abort) begin
         unique case (I_PRIV_ACC.sel)
            SEL_TAG_STAGING:  s_d.tag_stage = I_PRIV_ACC.wdata[42:13]; // RL18
            SEL_PAGE_SIZE:    s_d.size_sel  = I_PRIV_ACC.wdata;
            SEL_EXC_RET_ADDR: s_d.exception_return_address  = I_PRIV_ACC.wdata; // RL24
            SEL_IXLATE_ENTRY: s_d.ihold     = I_PRIV_ACC.wdata;
            SEL_DXLATE_ENTRY: s_d.dhold     = I_PRIV_ACC.wdata;
            default: ;
         endcase
      end

      // privileged register reads, answer one cycle later
      if (I_PRIV_ACC.rd && acc_ok && !dmm_abort) begin
         s_d.rd_valid = 1'b1;
         unique case (I_PRIV_ACC.sel)
            SEL_IXLATE_ENTRY: begin
               s_d.ihold   = large_pg ? large_q[s_q.large_ptr].entry
                                      : small_q[s_q.small_ptr].entry; // RL7
               s_d.rd_data = 64'h0; // RL7
            end
            SEL_DXLATE_ENTRY: begin
               s_d.dhold   = data_q[s_q.dptr].entry; // RL7
               s_d.rd_data = 64'h0;
            end
            SEL_IXLATE_HOLD:  s_d.rd_data = s_q.ihold;
            SEL_DXLATE_HOLD:  s_d.rd_data = s_q.dhold;
            SEL_EXC_RET_ADDR: s_d.rd_data = s_q.exception_return_address;
            SEL_FAULT_VA: begin
               s_d.rd_data = s_q.fault_va;
               s_d.locked  = 1'b0; // RL21
            end
            SEL_FAULT_STATUS: s_d.rd_data = {48'h0, s_q.fault_stat};
            SEL_EXC_SUMMARY: begin
               s_d.rd_data = {56'h0, s_q.exception_summary};
            end
            default:          s_d.rd_data = 64'h0;
         endcase
      end

      // data pointer advances on any entry access; instruction pointers on allowed ones, aborted or not
      if ((I_PRIV_ACC.wr || I_PRIV_ACC.rd) && acc_ok &&
          I_PRIV_ACC.sel == SEL_IXLATE_ENTRY) begin
         if (large_pg) s_d.large_ptr = s_q.large_ptr + 2'h1; // RL9 RL23
         else          s_d.small_ptr = s_q.small_ptr + 3'h1; // RL9 RL23
      end
      if ((I_PRIV_ACC.wr || I_PRIV_ACC.rd) &&
          I_PRIV_ACC.sel == SEL_DXLATE_ENTRY) begin
         s_d.dptr = (s_q.dptr == 3'(DATA_ENTRIES - 1)) ? 3'h0
                                                      : s_q.dptr + 3'h1;
      end

      // leaving privileged mode
      if (I_RETURN && s_q.seq == ST_PRIV) begin
         s_d.seq  = ST_RUN;
         s_d.priv = 1'b0;
      end

      // miss sequencing
      unique case (s_q.seq)
         ST_RUN, ST_PRIV: begin
            // data miss possible in privileged mode; instruction miss not
            if (I_DMISS && !s_q.locked) begin
               s_d.fault_va   = I_DMISS_VA; // RL19
               s_d.fault_stat = I_DMISS_STATUS; // RL19 RL21
               s_d.locked     = 1'b1; // RL19 RL24
               s_d.exception_return_address   = I_DMISS_PC; // RL19
               s_d.dmiss_kind = 1'b1;
               s_d.from_priv  = s_q.priv; // RL20
               s_d.flush      = 1'b1;
               s_d.drain      = DRAIN_CYCLES;
               s_d.seq        = ST_DRAIN;
            end else if (I_IMISS && !s_q.priv) begin
               s_d.exception_return_address   = I_IMISS_VPC; // RL16
               s_d.dmiss_kind = 1'b0;
               s_d.from_priv  = 1'b0;
               s_d.flush      = 1'b1; // RL16
               s_d.drain      = DRAIN_CYCLES;
               s_d.seq        = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // wait for in-flight work before taking the entry
            s_d.drain = s_q.drain - 4'h1; // RL16
            if (s_q.drain == 4'h1) s_d.seq = ST_VECTOR;
         end
         ST_VECTOR: begin
            s_d.priv      = 1'b1; // RL16
            s_d.vec_valid = 1'b1;
            s_d.vec = !s_q.dmiss_kind ? VEC_IMISS :
                      s_q.from_priv   ? VEC_DMISS_PRIV : VEC_DMISS; // RL19
            s_d.seq       = ST_PRIV;
         end
         default: s_d.seq = ST_RUN;
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SYS_RST) begin
         s_q     <= '0;
         s_q.seq <= ST_RUN;
      end else begin
         s_q <= s_d;
      end
   end

   // entry arrays: entry write loads staged tag and entry together
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SYS_RST) begin
         for (int i = 0; i < SMALL_ENTRIES; i++) small_q[i] <= '0;
         for (int i = 0; i < LARGE_ENTRIES; i++) large_q[i] <= '0;
         for (int i = 0; i < DATA_ENTRIES; i++)  data_q[i]  <= '0;
      end else if (I_PRIV_ACC.wr && acc_ok && !dmm_abort) begin
         if (I_PRIV_ACC.sel == SEL_IXLATE_ENTRY) begin
            if (large_pg)
               large_q[s_q.large_ptr] <= {1'b1, s_q.tag_stage,
                                          I_PRIV_ACC.wdata}; // RL18
            else
               small_q[s_q.small_ptr] <= {1'b1, s_q.tag_stage,
                                          I_PRIV_ACC.wdata}; // RL18
         end else if (I_PRIV_ACC.sel == SEL_DXLATE_ENTRY) begin
            data_q[s_q.dptr] <= {1'b1, s_q.tag_stage, I_PRIV_ACC.wdata};
         end
      end
   end

   // ==========================================================
   // outputs straight from flops, except trap pending, decoded from the shadow count
   assign O_RD_DATA      = s_q.rd_data;
   assign O_RD_VALID     = s_q.rd_valid;
   assign O_PRIV_MODE    = s_q.priv;
   assign O_FLUSH        = s_q.flush;
   assign O_VECTOR_VALID = s_q.vec_valid;
   assign O_VECTOR       = s_q.vec;
   assign O_TRAP_PENDING = (s_q.shadow != 6'h00); // RL3
   assign O_TRAP_RAISE   = s_q.raise;
endmodule : xlate_miss_priv_timing

// [xlate_miss_priv_timing_sva.sv]
// checker for the translation miss sequencer ports
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ns
module xlate_miss_chk
   import xlate_miss_pkg::*;
#(
   parameter int DATA_ENTRIES = 8
) (
   input wire logic        I_CLK_SYS,
   input wire logic        I_SYS_RST,
   input wire priv_acc_t   I_PRIV_ACC,
   input wire logic        I_PRIV_MODE_OVERRIDE,
   input wire logic        I_DMM_ERROR,
   input wire logic        I_IMISS,
   input wire logic        I_MACHINE_CHECK,
   input wire trap_class_t I_TRAP_OP,
   input wire logic        I_TRAP_ERR,
   input wire logic [63:0] O_RD_DATA,
   input wire logic        O_RD_VALID,
   input wire logic        O_PRIV_MODE,
   input wire logic        O_FLUSH,
   input wire logic        O_VECTOR_VALID,
   input wire logic [63:0] O_VECTOR,
   input wire logic        O_TRAP_PENDING,
   input wire logic        O_TRAP_RAISE
);
   // ==========================================================
   // properties
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);
   logic is_ibuf;
   // selectors 0..2 belong to the instruction buffer
   assign is_ibuf = I_PRIV_ACC.sel <= SEL_IXLATE_HOLD;
   chk_read_answer: assert property (
      I_PRIV_ACC.rd && !is_ibuf && (O_PRIV_MODE || I_PRIV_MODE_OVERRIDE)
      |=> O_RD_VALID)
      else $error("read not answered");
   chk_ovr_ignore: assert property (
      I_PRIV_ACC.rd && is_ibuf && !O_PRIV_MODE |=> !O_RD_VALID)
      else $error("unprivileged buffer read answered");
   chk_no_stray: assert property (!I_PRIV_ACC.rd |=> !O_RD_VALID)
      else $error("read valid without read");
   chk_entry_zero: assert property (
      I_PRIV_ACC.rd && I_PRIV_ACC.sel == SEL_DXLATE_ENTRY
      |=> O_RD_VALID && O_RD_DATA == 64'h0)
      else $error("entry read returned data");
   chk_imiss_flush: assert property (
      I_IMISS && !O_PRIV_MODE |=> O_FLUSH)
      else $error("instruction miss did not flush");
   chk_imiss_vec: assert property (
      I_IMISS && !O_PRIV_MODE
      |-> ##[2:10] (O_VECTOR_VALID && O_VECTOR == VEC_IMISS))
      else $error("instruction miss vector missing");
   chk_vec_priv: assert property (O_VECTOR_VALID |-> ##[0:1] O_PRIV_MODE)
      else $error("vector without privileged mode");
   chk_shadow_on: assert property (
      I_TRAP_OP != TRAP_NONE |=> O_TRAP_PENDING)
      else $error("trap shadow not opened");
   chk_machine_check_swallow: assert property (
      I_MACHINE_CHECK && I_TRAP_ERR |=> !O_TRAP_RAISE [*4])
      else $error("trap raised beside machine check");
   chk_data_hold: assert property (!O_RD_VALID |-> $stable(O_RD_DATA))
      else $error("read data moved without read");
   chk_dmm_abort: assert property (
      $past(I_DMM_ERROR) && I_PRIV_ACC.rd &&
      I_PRIV_ACC.sel == SEL_IXLATE_ENTRY |=> !O_RD_VALID)
      else $error("entry read not aborted by memory error");
endmodule : xlate_miss_chk
bind xlate_miss_priv_timing xlate_miss_chk #(
   .DATA_ENTRIES(DATA_ENTRIES)) xlate_miss_chk_i (
   .I_CLK_SYS, .I_SYS_RST, .I_PRIV_ACC, .I_PRIV_MODE_OVERRIDE,
   .I_DMM_ERROR, .I_IMISS, .I_MACHINE_CHECK, .I_TRAP_OP,
   .I_TRAP_ERR, .O_RD_DATA, .O_RD_VALID, .O_PRIV_MODE, .O_FLUSH,
   .O_VECTOR_VALID, .O_VECTOR, .O_TRAP_PENDING, .O_TRAP_RAISE);

// [fw_model.sv]
// firmware model: privileged register accesses with safe spacing
// assumes the core clock; one access at a time, idle cycles owed after
`timescale 1ns/1ns
module fw_model
   import xlate_miss_pkg::*;
(
   input  wire logic clk,
   output priv_acc_t acc
);
   int owed = 0;
   // no code base, address space or flush write and no physical store
   // is issued, so exceptions and delays around them never arise
   initial acc = '0;
   // ==========================================================
   // one access; idle cycles are paid before the next one
   task automatic op(input logic w, input logic [3:0] s,
                     input logic [63:0] d);
      int gap;
      gap = 0;
      if (s == SEL_IXLATE_ENTRY || s == SEL_DXLATE_ENTRY)
         gap = w ? 2 : 3;
      if (w && s == SEL_PAGE_SIZE)
         gap = 1;
      repeat (owed) @(posedge clk);
      owed = gap;
      @(posedge clk);
      acc <= '{wr: w, rd: !w, sel: s, wdata: d};
      @(posedge clk);
      // released lines flip so stale values are never trusted
      acc <= '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: ~d};
   endtask : op
endmodule : fw_model

// [xlate_miss_priv_timing_tb.sv]
// testbench for the translation miss sequencer
// assumes the checker binds itself onto the design instance
`timescale 1ns/1ns
module xlate_miss_priv_timing_tb;
   import xlate_miss_pkg::*;
   logic        clk, rst, ovr, imiss, dmiss, machine_check, ret, terr, data_memmgmt_error;
   logic        rvalid, priv, flush, vvalid, pend, raise;
   logic [63:0] virtual_program_counter, va, pc, rdata, vec;
   logic [15:0] stat;
   trap_class_t top;
   priv_acc_t   acc;
   int          err_count, n_compared, cyc;
   xlate_miss_priv_timing #(.DATA_ENTRIES(8)) xlate_miss_priv_timing_i (
      .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_PRIV_ACC(acc),
      .I_PRIV_MODE_OVERRIDE(ovr), .I_IMISS(imiss), .I_IMISS_VPC(virtual_program_counter),
      .I_DMISS(dmiss), .I_DMISS_VA(va), .I_DMISS_PC(pc),
      .I_DMISS_STATUS(stat), .I_DMM_ERROR(data_memmgmt_error), .I_MACHINE_CHECK(machine_check),
      .I_MACHINE_CHECK_PC(pc), .I_RETURN(ret), .I_TRAP_OP(top), .I_TRAP_ERR(terr),
      .O_RD_DATA(rdata), .O_RD_VALID(rvalid), .O_PRIV_MODE(priv),
      .O_FLUSH(flush), .O_VECTOR_VALID(vvalid), .O_VECTOR(vec),
      .O_TRAP_PENDING(pend), .O_TRAP_RAISE(raise));
   fw_model fw_model_i (.clk(clk), .acc(acc));
   // ==========================================================
   // helpers
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // read data stands in the cycle after the read strobe
   task automatic rd(input logic [3:0] s, output logic [63:0] d,
                     output logic v);
      fw_model_i.op(1'b0, s, 64'h0);
      @(negedge clk);
      v = rvalid;
      d = rdata;
   endtask : rd
   task automatic miss_d(input logic [63:0] a, input logic [63:0] p,
                         input logic f);
      @(posedge clk);
      {dmiss, va, pc, stat} <= {1'b1, a, p, 16'h0018};
      @(posedge clk);
      dmiss <= 1'b0;
      @(negedge clk);
      cmp(64'(flush), 64'(f));
   endtask : miss_d
   // bounded wait for the entry vector, then privileged mode
   task automatic wait_vec(input logic [63:0] exp);
      for (int n = 0; n < 20 && vvalid !== 1'b1; n++) @(negedge clk);
      cmp(vec, exp);
      @(negedge clk);
      cmp(64'(priv), 64'h1);
   endtask : wait_vec
   task automatic pulse_trap(input trap_class_t c, input logic e,
                             input logic m, output int n);
      @(posedge clk);
      top <= c;
      @(posedge clk);
      top <= TRAP_NONE;
      {terr, machine_check} <= {e, m};
      @(posedge clk);
      {terr, machine_check} <= 2'h0;
      n = 0;
      repeat (70) begin
         @(negedge clk);
         n += (e ? raise : pend) === 1'b1;
      end
   endtask : pulse_trap
   // ==========================================================
   // scenarios
   task automatic t_dmiss;
      logic [63:0] d;
      logic        v;
      miss_d(64'h0000_0123_4567_8000, 64'h0000_0000_0001_0040, 1'b1);
      wait_vec(VEC_DMISS);
      rd(SEL_FAULT_STATUS, d, v);
      cmp(d, 64'h18);
      rd(SEL_EXC_RET_ADDR, d, v);
      cmp(d, 64'h1_0040);
      // prefetch hint: firmware steps over the faulting instruction
      fw_model_i.op(1'b1, SEL_EXC_RET_ADDR, d + 64'h4);
      rd(SEL_EXC_RET_ADDR, d, v);
      cmp(d, 64'h1_0044);
      // ignored while locked
      miss_d(64'h0000_0000_DEAD_0000, 64'h8, 1'b0);
      repeat (10) @(negedge clk);
      rd(SEL_FAULT_VA, d, v);
      cmp(d, 64'h0000_0123_4567_8000);
      miss_d(64'h0000_0000_0BAD_2000, 64'h4, 1'b1);
      wait_vec(VEC_DMISS_PRIV);
      rd(SEL_FAULT_VA, d, v);
      cmp(d, 64'h0BAD_2000);
      // data fill: staged tag, entry, then the hold copy
      fw_model_i.op(1'b1, SEL_TAG_STAGING, 64'h0BAD_2000);
      fw_model_i.op(1'b1, SEL_DXLATE_ENTRY, 64'h0A5A);
      rd(SEL_DXLATE_HOLD, d, v);
      cmp(d, 64'h0A5A);
      rd(SEL_DXLATE_ENTRY, d, v);
      cmp(64'(v), 64'h1);
      cmp(d, 64'h0);
      $display("test dmiss done");
   endtask : t_dmiss
   task automatic t_trap;
      logic [5:0]  len [6] = '{SHADOW_INT, SHADOW_MULL, SHADOW_MULQ,
                               SHADOW_FLT, SHADOW_DIVS, SHADOW_DIVT};
      int          n;
      logic [63:0] d;
      logic        v;
      for (int k = 0; k < 6; k++) begin
         pulse_trap(trap_class_t'(k + 1), 1'b0, 1'b0, n);
         cmp(64'(n + 1), 64'(len[k]));
      end
      pulse_trap(TRAP_INT, 1'b1, 1'b0, n);
      cmp(64'(n), 64'h1);
      pulse_trap(TRAP_INT, 1'b1, 1'b1, n);
      cmp(64'(n), 64'h0);
      rd(SEL_EXC_SUMMARY, d, v);
      cmp(64'(d[0]), 64'h1);
      $display("test trap done");
   endtask : t_trap
   task automatic t_ibuf;
      logic [63:0] d;
      logic        v;
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      {ret, ovr} <= 2'h1;
      repeat (3) @(negedge clk);
      cmp(64'(priv), 64'h0);
      rd(SEL_IXLATE_HOLD, d, v);
      cmp(64'(v), 64'h0);
      @(posedge clk);
      {ovr, imiss, virtual_program_counter} <= {2'h1, 64'h0000_0000_2000_4000};
      @(posedge clk);
      imiss <= 1'b0;
      wait_vec(VEC_IMISS);
      rd(SEL_EXC_RET_ADDR, d, v);
      cmp(d, 64'h2000_4000);
      fw_model_i.op(1'b1, SEL_TAG_STAGING, 64'h2000_4000);
      fw_model_i.op(1'b1, SEL_PAGE_SIZE, 64'h0);
      fw_model_i.op(1'b1, SEL_IXLATE_ENTRY, 64'h0F00);
      rd(SEL_IXLATE_HOLD, d, v);
      cmp(d, 64'h0F00);
      rd(SEL_IXLATE_ENTRY, d, v);
      cmp(64'(v), 64'h1);
      cmp(d, 64'h0);
      rd(SEL_IXLATE_HOLD, d, v);
      cmp(64'(v), 64'h1);
      cmp(d, 64'h0);
      // memory error one cycle ahead of the entry read aborts it
      @(posedge clk);
      data_memmgmt_error <= 1'b1;
      rd(SEL_IXLATE_ENTRY, d, v);
      cmp(64'(v), 64'h0);
      @(posedge clk);
      data_memmgmt_error <= 1'b0;
      $display("test ibuf done");
   endtask : t_ibuf
   // ==========================================================
   // clock, watchdog and main sequence
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         end_of_test;
      end
   end
   initial begin
      {clk, rst, ovr, imiss, dmiss, machine_check, ret, terr, data_memmgmt_error} = 9'h080;
      {virtual_program_counter, va, pc, stat} = '0;
      top = TRAP_NONE;
      {err_count, n_compared, cyc} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      cmp(64'({priv, vvalid, rvalid, pend}), 64'h0);
      t_dmiss;
      t_trap;
      t_ibuf;
      end_of_test;
   end
endmodule : xlate_miss_priv_timing_tb
